/* shared/cao_pkg.sv */
// constants and types shared by the charger result and option register bank
package cao_pkg;

    // ==========================================================
    // command codes of the word registers
    localparam logic [7:0]  CAO_CMD_ACTIVE_LIMIT = 8'h22;
    localparam logic [7:0]  CAO_CMD_VOLT_POWER   = 8'h23;
    localparam logic [7:0]  CAO_CMD_BATT_CURRENT = 8'h24;
    localparam logic [7:0]  CAO_CMD_IIN_COMP     = 8'h25;
    localparam logic [7:0]  CAO_CMD_SYS_BATT     = 8'h26;
    localparam logic [7:0]  CAO_CMD_OPTION_ONE   = 8'h30;

    // ==========================================================
    // values after reset
    localparam logic [15:0] CAO_OPTION_RESET     = 16'h3300;
    localparam logic [15:0] CAO_WORD_ZERO        = 16'h0000;
    localparam logic [6:0]  CAO_LIMIT_RESET      = 7'h00;
    localparam logic [7:0]  CAO_LIMIT_LOW_BYTE   = 8'h00;
    localparam logic [7:0]  CAO_READ_FILL        = 8'h00;

    // ==========================================================
    // option register field positions
    localparam int CAO_BIT_BATT_MON_EN   = 15;
    localparam int CAO_BIT_HOT_ALERT_EN  = 14;
    localparam int CAO_BIT_PSENSE_HI     = 13;
    localparam int CAO_BIT_PSENSE_LO     = 12;
    localparam int CAO_BIT_INPUT_SHUNT   = 11;
    localparam int CAO_BIT_CHARGE_SHUNT  = 10;
    localparam int CAO_BIT_POWER_GAIN    = 9;
    localparam int CAO_BIT_FAST_COMP     = 8;
    localparam logic [1:0]  CAO_PSENSE_OFF = 2'b11;

    // ==========================================================
    // conversion and serial constants
    localparam logic [6:0]  CAO_DCHG_FULL        = 7'h7F;
    localparam logic [3:0]  CAO_BITS_PER_BYTE    = 4'h8;
    localparam logic [3:0]  CAO_BIT_CNT_ZERO     = 4'h0;
    localparam logic [6:0]  CAO_SMB_ADDR_DEFAULT = 7'h09;

    typedef enum logic [3:0] {
        CAO_IDLE,
        CAO_ADDR,
        CAO_ADDR_ACK,
        CAO_CMD,
        CAO_CMD_ACK,
        CAO_WR_DATA,
        CAO_WR_ACK,
        CAO_RD_DATA,
        CAO_RD_ACK
    } cao_smb_state_t;

endpackage

/* hw/cao_sync.sv */
// two flip-flop synchroniser for one pin
`timescale 1ns/1ns
module cao_sync
    import cao_pkg::*;
(
    input  wire logic clk,
    input  wire logic srst,
    input  wire logic pin_in,
    output logic      pin_sync
);

    typedef struct packed {
        logic meta;
        logic stable;
    } cao_sync_t;

    cao_sync_t st_reg;
    cao_sync_t st_next;

    // ==========================================================
    // next state
    always_comb
    begin
        st_next        = st_reg;
        st_next.meta   = pin_in;
        st_next.stable = st_reg.meta;
    end

    // idle bus level is high, so reset to high
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            st_reg <= '{meta: 1'b1, stable: 1'b1};
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign pin_sync = st_reg.stable;

endmodule

/* hw/cao_hold.sv */
// result holding register, loaded on each conversion strobe
`timescale 1ns/1ns
module cao_hold
    import cao_pkg::*;
#(
    parameter int WIDTH = 16
)
(
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] value_in,
    output logic      [WIDTH-1:0] value_out
);

    typedef struct packed {
        logic [WIDTH-1:0] value;
    } cao_hold_t;

    cao_hold_t st_reg;
    cao_hold_t st_next;

    // ==========================================================
    // next state
    always_comb
    begin
        st_next = st_reg;
        if (load)
        begin
            st_next.value = value_in;
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign value_out = st_reg.value;

endmodule

/* hw/cao_regbank.sv */
// conversion result and charger option registers behind an SMBus slave
// How it works
// - input voltage code sits in upper byte of voltage/power word
// - system power code sits in lower byte, scaled by range select
// - voltage/power word is read only: input voltage high, power low
// - charge current seven bits at 14-8, bit 15 reads zero
// - discharge current seven bits at 6-0, saturating, bit 7 zero
// - input current code in upper byte, scaled by input shunt
// - comparator input code in lower byte, scaled by range select
// - system voltage code in upper byte of system/battery word
// - battery voltage code in lower byte, same scaling
// - active limit low byte reserved, reads zero
// - option register resets to 3300h
// - bit 15 enables battery current buffer, forced off in low power
// - bit 14 enables low power hot alert, default off
// - bits 13-12 pick power sensing; 11 turns it off
// - low power mode keeps power sensing and its buffer off
// - bit 11 selects input shunt value, default ten milliohm
// - bit 10 selects charge shunt value, default ten milliohm
// - bit 9 selects system power gain, default high gain
`timescale 1ns/1ns
module cao_regbank
    import cao_pkg::*;
#(
    parameter logic [6:0] SMB_ADDR = CAO_SMB_ADDR_DEFAULT
)
(
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    input  wire logic       adc_update,
    input  wire logic [7:0] input_voltage_code,
    input  wire logic [7:0] system_power_code,
    input  wire logic [6:0] charge_current_code,
    input  wire logic [7:0] discharge_current_code,
    input  wire logic [7:0] input_current_code,
    input  wire logic [7:0] comparator_input_code,
    input  wire logic [7:0] system_voltage_code,
    input  wire logic [7:0] battery_voltage_code,
    input  wire logic       limit_update,
    input  wire logic [6:0] active_limit_code,
    input  wire logic       lowpower_mode,
    output logic            batt_current_monitor_en,
    output logic            lowpower_hot_alert_en,
    output logic [1:0]      system_power_sense_cfg,
    output logic            system_power_sense_on,
    output logic            input_shunt_select,
    output logic            charge_shunt_select,
    output logic            system_power_gain_sel,
    output logic            fast_comp_low_shunt_en,
    output logic [7:0]      option_low_byte
);

    typedef struct packed {
        cao_smb_state_t state;
        logic [3:0]     bit_cnt;
        logic [7:0]     shift;
        logic [7:0]     tx;
        logic [7:0]     cmd;
        logic [7:0]     wr_low;
        logic [1:0]     byte_idx;
        logic           rw;
        logic [15:0]    rd_word;
        logic           scl_d;
        logic           sda_d;
        logic           sda_oe;
        logic [15:0]    option;
        logic           batt_mon_en;
        logic           psense_on;
    } cao_state_t;

    cao_state_t  st_reg;
    cao_state_t  st_next;
    logic        scl_s;
    logic        sda_s;
    logic [6:0]  dchg_sat;
    logic [63:0] adc_words;
    logic [6:0]  limit_word;
    logic [15:0] read_word;

    // ==========================================================
    // pin synchronisers
    cao_sync u_sync_scl
    (
        .clk      (clk),
        .srst     (srst),
        .pin_in   (scl_in),
        .pin_sync (scl_s)
    );
    cao_sync u_sync_sda
    (
        .clk      (clk),
        .srst     (srst),
        .pin_in   (sda_in),
        .pin_sync (sda_s)
    );

    // ==========================================================
    // result holding registers
    // saturate discharge code
    assign dchg_sat = (discharge_current_code > {1'b0, CAO_DCHG_FULL})
                    ? CAO_DCHG_FULL : discharge_current_code[6:0];

    // one strobe loads all four words, so a read never mixes two samples
    // input voltage upper
    cao_hold #(.WIDTH(64)) u_hold_adc
    (
        .clk       (clk),
        .srst      (srst),
        .load      (adc_update),
        .value_in  ({input_voltage_code, system_power_code,
                     1'b0, charge_current_code, 1'b0, dchg_sat,
                     input_current_code, comparator_input_code,
                     system_voltage_code, battery_voltage_code}),
        .value_out (adc_words)
    );

    cao_hold #(.WIDTH(7)) u_hold_limit
    (
        .clk       (clk),
        .srst      (srst),
        .load      (limit_update),
        .value_in  (active_limit_code),
        .value_out (limit_word)
    );

    // ==========================================================
    // read multiplexer
    always_comb
    begin
        read_word = CAO_WORD_ZERO;
        if (st_reg.cmd == CAO_CMD_ACTIVE_LIMIT)
        begin
            read_word = {1'b0, limit_word, CAO_LIMIT_LOW_BYTE};
        end
        else if (st_reg.cmd >= CAO_CMD_VOLT_POWER &&
                 st_reg.cmd <= CAO_CMD_SYS_BATT)
        begin
            read_word = adc_words[{2'(CAO_CMD_SYS_BATT - st_reg.cmd),
                                   4'h0} +: 16];
        end
        else if (st_reg.cmd == CAO_CMD_OPTION_ONE)
        begin
            read_word = st_reg.option;
        end
    end

    // ==========================================================
    // serial protocol and register update
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    assign scl_rise   = scl_s & ~st_reg.scl_d;
    assign scl_fall   = ~scl_s & st_reg.scl_d;
    assign start_seen = scl_s & st_reg.scl_d & st_reg.sda_d & ~sda_s;
    assign stop_seen  = scl_s & st_reg.scl_d & ~st_reg.sda_d & sda_s;

    always_comb
    begin
        st_next       = st_reg;
        st_next.scl_d = scl_s;
        st_next.sda_d = sda_s;
        if (start_seen)
        begin
            st_next.state   = CAO_ADDR;
            st_next.bit_cnt = CAO_BIT_CNT_ZERO;
            st_next.sda_oe  = 1'b0;
        end
        else if (stop_seen)
        begin
            st_next.state  = CAO_IDLE;
            st_next.sda_oe = 1'b0;
        end
        else
        begin
            case (st_reg.state)
                CAO_ADDR, CAO_CMD, CAO_WR_DATA:
                begin
                    if (scl_rise)
                    begin
                        st_next.shift   = {st_reg.shift[6:0], sda_s};
                        st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
                    end
                    else if (scl_fall && st_reg.bit_cnt == CAO_BITS_PER_BYTE)
                    begin
                        st_next.bit_cnt = CAO_BIT_CNT_ZERO;
                        st_next.sda_oe  = 1'b1;
                        if (st_reg.state == CAO_ADDR)
                        begin
                            if (st_reg.shift[7:1] == SMB_ADDR)
                            begin
                                st_next.state   = CAO_ADDR_ACK;
                                st_next.rw      = st_reg.shift[0];
                                st_next.rd_word = read_word;
                            end
                            else
                            begin
                                st_next.state  = CAO_IDLE;
                                st_next.sda_oe = 1'b0;
                            end
                        end
                        else if (st_reg.state == CAO_CMD)
                        begin
                            st_next.state    = CAO_CMD_ACK;
                            st_next.cmd      = st_reg.shift;
                            st_next.byte_idx = 2'b00;
                        end
                        else
                        begin
                            st_next.state = CAO_WR_ACK;
                            if (st_reg.byte_idx == 2'b00)
                            begin
                                st_next.wr_low = st_reg.shift;
                            end
                            // only the option word takes writes
                            else if (st_reg.byte_idx == 2'b01 &&
                                     st_reg.cmd == CAO_CMD_OPTION_ONE)
                            begin
                                st_next.option = {st_reg.shift,
                                                  st_reg.wr_low};
                            end
                        end
                    end
                end
                CAO_ADDR_ACK:
                begin
                    if (scl_fall)
                    begin
                        if (st_reg.rw)
                        begin
                            st_next.state    = CAO_RD_DATA;
                            st_next.tx       = st_reg.rd_word[7:0];
                            st_next.sda_oe   = ~st_reg.rd_word[7];
                            st_next.byte_idx = 2'b00;
                        end
                        else
                        begin
                            st_next.state  = CAO_CMD;
                            st_next.sda_oe = 1'b0;
                        end
                    end
                end
                CAO_CMD_ACK, CAO_WR_ACK:
                begin
                    if (scl_fall)
                    begin
                        st_next.state  = CAO_WR_DATA;
                        st_next.sda_oe = 1'b0;
                        if (st_reg.state == CAO_WR_ACK &&
                            st_reg.byte_idx != 2'b10)
                        begin
                            st_next.byte_idx = st_reg.byte_idx + 2'b01;
                        end
                    end
                end
                CAO_RD_DATA:
                begin
                    if (scl_rise)
                    begin
                        st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
                    end
                    else if (scl_fall)
                    begin
                        if (st_reg.bit_cnt == CAO_BITS_PER_BYTE)
                        begin
                            st_next.state   = CAO_RD_ACK;
                            st_next.sda_oe  = 1'b0;
                            st_next.bit_cnt = CAO_BIT_CNT_ZERO;
                        end
                        else
                        begin
                            st_next.tx     = {st_reg.tx[6:0], 1'b0};
                            st_next.sda_oe = ~st_reg.tx[6];
                        end
                    end
                end
                CAO_RD_ACK:
                begin
                    // a released line is the host's not-acknowledge
                    if (scl_rise && sda_s)
                    begin
                        st_next.state = CAO_IDLE;
                    end
                    else if (scl_fall)
                    begin
                        st_next.state = CAO_RD_DATA;
                        st_next.tx     = (st_reg.byte_idx == 2'b00)
                                       ? st_reg.rd_word[15:8] : CAO_READ_FILL;
                        st_next.sda_oe = ~st_next.tx[7];
                        st_next.byte_idx = 2'b01;
                    end
                end
                default:
                begin
                    st_next.sda_oe = 1'b0;
                end
            endcase
        end
        st_next.batt_mon_en = st_next.option[CAO_BIT_BATT_MON_EN]
                            & ~lowpower_mode;
        // field value 11 turns sensing off
        st_next.psense_on = (st_next.option[CAO_BIT_PSENSE_HI:
                                            CAO_BIT_PSENSE_LO]
                             != CAO_PSENSE_OFF) & ~lowpower_mode;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            st_reg          <= '0;
            st_reg.state    <= CAO_IDLE;
            st_reg.scl_d    <= 1'b1;
            st_reg.sda_d    <= 1'b1;
            st_reg.option   <= CAO_OPTION_RESET;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // ==========================================================
    // outputs, all taken from registered state
    // pin is open drain, so the data level is always low
    assign sda_out                 = 1'b0;
    assign sda_oe                  = st_reg.sda_oe;
    assign batt_current_monitor_en = st_reg.batt_mon_en;
    assign lowpower_hot_alert_en   = st_reg.option[CAO_BIT_HOT_ALERT_EN];
    assign system_power_sense_cfg  =
        st_reg.option[CAO_BIT_PSENSE_HI:CAO_BIT_PSENSE_LO];
    assign system_power_sense_on   = st_reg.psense_on;
    assign input_shunt_select      = st_reg.option[CAO_BIT_INPUT_SHUNT];
    assign charge_shunt_select     = st_reg.option[CAO_BIT_CHARGE_SHUNT];
    assign system_power_gain_sel   = st_reg.option[CAO_BIT_POWER_GAIN];
    assign fast_comp_low_shunt_en  = st_reg.option[CAO_BIT_FAST_COMP];
    assign option_low_byte         = st_reg.option[7:0];

endmodule

/* tb/cao_regbank_properties.sv */
// assertions on the pins of the charger register bank
`timescale 1ns/1ns
module cao_regbank_properties
(
    input wire logic       clk,
    input wire logic       srst,
    input wire logic       scl_in,
    input wire logic       sda_out,
    input wire logic       sda_oe,
    input wire logic       lowpower_mode,
    input wire logic       batt_current_monitor_en,
    input wire logic       lowpower_hot_alert_en,
    input wire logic [1:0] system_power_sense_cfg,
    input wire logic       system_power_sense_on,
    input wire logic       input_shunt_select,
    input wire logic       charge_shunt_select,
    input wire logic       system_power_gain_sel,
    input wire logic       fast_comp_low_shunt_en,
    input wire logic [7:0] option_low_byte
);
    // ==========
    // option pins as bits 14-0 of the option word
    logic [14:0] opt;
    assign opt = {lowpower_hot_alert_en, system_power_sense_cfg,
                  input_shunt_select, charge_shunt_select,
                  system_power_gain_sel, fast_comp_low_shunt_en,
                  option_low_byte};
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    a_reset_word:
        assert property ($fell(srst) |-> opt == 15'h3300)
        else $error("option pins differ from reset word");
    a_reset_quiet:
        assert property ($fell(srst) |-> !sda_oe && !batt_current_monitor_en
                         && !system_power_sense_on)
        else $error("outputs active after reset");
    a_monitor_lowpower:
        assert property (lowpower_mode |=> !batt_current_monitor_en)
        else $error("current monitor on in low power");
    a_sense_lowpower:
        assert property (lowpower_mode |=> !system_power_sense_on)
        else $error("power sensing on in low power");
    // config must sit still two cycles so output lag cannot matter
    a_sense_config:
        assert property (!lowpower_mode && $stable(system_power_sense_cfg)
                         ##1 $stable(system_power_sense_cfg) |->
                         system_power_sense_on ==
                         (system_power_sense_cfg != 2'h3))
        else $error("power sensing disagrees with config");
    a_option_quiet:
        assert property (!scl_in [*8] |-> $stable(opt))
        else $error("option changed with bus clock idle low");
    a_ack_in_low:
        assert property ($rose(sda_oe) |-> !scl_in && !sda_out)
        else $error("data line taken while clock high");
    a_drive_holds:
        assert property (sda_oe && scl_in |=> sda_oe)
        else $error("data line released while clock high");
    c_ack: cover property ($rose(sda_oe));
    c_opt_change: cover property ($changed(opt));
    c_sense_on: cover property ($rose(system_power_sense_on));
endmodule
bind cao_regbank cao_regbank_properties cao_regbank_properties_i (
    .clk, .srst, .scl_in, .sda_out, .sda_oe, .lowpower_mode,
    .batt_current_monitor_en, .lowpower_hot_alert_en, .system_power_sense_cfg,
    .system_power_sense_on, .input_shunt_select, .charge_shunt_select,
    .system_power_gain_sel, .fast_comp_low_shunt_en, .option_low_byte
);

/* tb/cao_smb_host.sv */
// smbus host that issues word reads and writes
`timescale 1ns/1ns
module cao_smb_host
    import cao_pkg::*;
#(
    parameter logic [6:0] ADDR = CAO_SMB_ADDR_DEFAULT
)
(
    input  wire logic clk,
    input  wire logic sda,
    output logic      scl,
    output logic      host_oe
);
    // ==========
    // ph is a quarter bit in clocks; raise it for a slow host
    int ph = 5;
    int naks = 0;
    initial
    begin
        scl = 1'h1;
        host_oe = 1'h0;
    end
    task automatic tick();
        repeat (ph) @(negedge clk);
    endtask
    task automatic bit_io(input logic b, output logic r);
        tick();
        host_oe = !b;
        tick();
        scl = 1'h1;
        tick();
        r = sda;
        tick();
        scl = 1'h0;
    endtask
    // on a write byte the device must pull the ninth bit low
    task automatic byte_io(input logic [7:0] d, input logic rd,
                           input logic a, output logic [7:0] q);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], q[i]);
        bit_io(rd ? a : 1'h1, r);
        if (!rd && r)
            naks++;
    endtask
    // also serves as repeated start
    task automatic start_cond();
        tick();
        host_oe = 1'h0;
        tick();
        scl = 1'h1;
        tick();
        host_oe = 1'h1;
        tick();
        scl = 1'h0;
    endtask
    task automatic stop_cond();
        tick();
        host_oe = 1'h1;
        tick();
        scl = 1'h1;
        tick();
        host_oe = 1'h0;
        tick();
    endtask
    task automatic write_word(input logic [7:0] cmd, input logic [15:0] w);
        logic [7:0] q;
        start_cond();
        byte_io({ADDR, 1'h0}, 1'h0, 1'h0, q);
        byte_io(cmd, 1'h0, 1'h0, q);
        byte_io(w[7:0], 1'h0, 1'h0, q);
        byte_io(w[15:8], 1'h0, 1'h0, q);
        stop_cond();
    endtask
    // word read, host nacks the high byte
    task automatic read_word(input logic [7:0] cmd, output logic [15:0] w);
        logic [7:0] q;
        start_cond();
        byte_io({ADDR, 1'h0}, 1'h0, 1'h0, q);
        byte_io(cmd, 1'h0, 1'h0, q);
        start_cond();
        byte_io({ADDR, 1'h1}, 1'h0, 1'h0, q);
        byte_io(8'hFF, 1'h1, 1'h0, w[7:0]);
        byte_io(8'hFF, 1'h1, 1'h1, w[15:8]);
        stop_cond();
    endtask
endmodule

/* tb/cao_regbank_test.sv */
// self-checking bench for the charger register bank
`timescale 1ns/1ns
module cao_regbank_test
    import cao_pkg::*;
;
    // ==========
    // stimulus and pins
    logic        clk = 1'h0;
    logic        srst = 1'h1;
    logic        adc_update = 1'h0;
    logic        limit_update = 1'h0;
    logic        lowpower_mode = 1'h0;
    logic [6:0]  charge_current_code = 7'h00;
    logic [6:0]  active_limit_code = 7'h00;
    logic [7:0]  discharge_current_code = 8'h00;
    logic [15:0] vp = 16'h0000;
    logic [15:0] ic = 16'h0000;
    logic [15:0] sv = 16'h0000;
    logic        scl_in, sda_in, sda_out, sda_oe, host_oe;
    logic        batt_current_monitor_en, lowpower_hot_alert_en;
    logic        system_power_sense_on, input_shunt_select;
    logic        charge_shunt_select, system_power_gain_sel;
    logic        fast_comp_low_shunt_en;
    logic [1:0]  system_power_sense_cfg;
    logic [7:0]  option_low_byte;
    logic [15:0] opts [4] = '{16'hCEA5, 16'h9200, 16'h2C5A, 16'h3300};
    int          mismatches = 0;
    int          n_tests = 0;
    // open drain line with pull-up
    assign sda_in = !(host_oe || (sda_oe && !sda_out));
    always #20 clk = ~clk;
    cao_regbank cao_regbank_i (
        .clk, .srst, .scl_in, .sda_in, .sda_out, .sda_oe, .adc_update,
        .input_voltage_code(vp[15:8]), .system_power_code(vp[7:0]),
        .charge_current_code, .discharge_current_code,
        .input_current_code(ic[15:8]), .comparator_input_code(ic[7:0]),
        .system_voltage_code(sv[15:8]), .battery_voltage_code(sv[7:0]),
        .limit_update, .active_limit_code, .lowpower_mode,
        .batt_current_monitor_en, .lowpower_hot_alert_en,
        .system_power_sense_cfg, .system_power_sense_on, .input_shunt_select,
        .charge_shunt_select, .system_power_gain_sel, .fast_comp_low_shunt_en,
        .option_low_byte
    );
    cao_smb_host cao_smb_host_i (.clk, .sda(sda_in), .scl(scl_in), .host_oe);
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [7:0] cmd, input logic [15:0] exp);
        logic [15:0] r;
        cao_smb_host_i.read_word(cmd, r);
        check(r, exp);
    endtask
    task automatic check_pins(input logic [15:0] o);
        repeat (3) @(negedge clk);
        check({batt_current_monitor_en, lowpower_hot_alert_en,
               system_power_sense_cfg, input_shunt_select,
               charge_shunt_select, system_power_gain_sel,
               fast_comp_low_shunt_en, option_low_byte},
              {o[15] && !lowpower_mode, o[14:0]});
        check({15'h0000, system_power_sense_on},
              {15'h0000, o[13:12] != 2'h3 && !lowpower_mode});
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // about 30 word transfers of under 1000 clocks each, the two slow-host ones under 2400
    initial
    begin
        #2400000;
        mismatches++;
        tally_and_finish();
    end
    initial
    begin
        repeat (5) @(negedge clk);
        srst = 1'h0;
        repeat (4) @(negedge clk);
        rd_chk(CAO_CMD_OPTION_ONE, 16'h3300);
        check_pins(16'h3300);
        rd_chk(CAO_CMD_ACTIVE_LIMIT, 16'h0000);
        $display("reset test done");
        foreach (opts[i])
        begin
            cao_smb_host_i.write_word(CAO_CMD_OPTION_ONE, opts[i]);
            rd_chk(CAO_CMD_OPTION_ONE, opts[i]);
            check_pins(opts[i]);
            lowpower_mode = 1'h1;
            check_pins(opts[i]);
            lowpower_mode = 1'h0;
        end
        $display("option test done");
        for (int k = 0; k < 2; k++)
        begin
            vp = k ? 16'h00A5 : 16'hFF5A;
            ic = k ? 16'h3C81 : 16'h81C3;
            sv = k ? 16'h18E7 : 16'hE718;
            charge_current_code = k ? 7'h01 : 7'h7F;
            discharge_current_code = k ? 8'h2B : 8'hC3;
            adc_update = 1'h1;
            @(negedge clk);
            adc_update = 1'h0;
            cao_smb_host_i.write_word(CAO_CMD_VOLT_POWER, 16'h1234);
            rd_chk(CAO_CMD_VOLT_POWER, vp);
            rd_chk(CAO_CMD_BATT_CURRENT, {1'h0, charge_current_code,
                   1'h0, k ? 7'h2B : 7'h7F});
            rd_chk(CAO_CMD_IIN_COMP, ic);
            rd_chk(CAO_CMD_SYS_BATT, sv);
        end
        cao_smb_host_i.write_word(CAO_CMD_SYS_BATT, 16'h1234);
        rd_chk(CAO_CMD_SYS_BATT, 16'h18E7);
        cao_smb_host_i.write_word(8'h40, 16'h1234);
        rd_chk(8'h40, 16'h0000);
        $display("result test done");
        active_limit_code = 7'h55;
        limit_update = 1'h1;
        @(negedge clk);
        limit_update = 1'h0;
        cao_smb_host_i.write_word(CAO_CMD_ACTIVE_LIMIT, 16'hFFFF);
        rd_chk(CAO_CMD_ACTIVE_LIMIT, 16'h5500);
        $display("limit test done");
        cao_smb_host_i.ph = 12;
        cao_smb_host_i.write_word(CAO_CMD_OPTION_ONE, 16'h1E00);
        rd_chk(CAO_CMD_OPTION_ONE, 16'h1E00);
        check(16'(cao_smb_host_i.naks), 16'h0000);
        $display("slow host test done");
        tally_and_finish();
    end
endmodule
